// *** etdr_pkg.sv ***
package etdr_pkg;

	// ==============================================================
	// Register offsets (byte addresses, one word each)
	localparam logic [7:0] CTRL_ADDR   = 8'h00;
	localparam logic [7:0] COUNT_ADDR  = 8'h04;
	localparam logic [7:0] DOUT_ADDR   = 8'h08;
	localparam logic [7:0] DDIR_ADDR   = 8'h0C;
	localparam logic [7:0] DBITS_ADDR  = 8'h10;

	// ==============================================================
	// Control register fields
	localparam int CTRL_EDGE_BIT  = 0;     // 1 = rising, 0 = falling
	localparam int CTRL_MODE_BIT  = 1;     // 1 = read then clear
	localparam int CTRL_CLEAR_BIT = 2;     // Write 1 clears count now

	// ==============================================================
	// Widths and reset values
	localparam int          COUNT_W      = 32;
	localparam int          DIO_W        = 8;
	localparam int          ADDR_W       = 8;
	localparam int          DATA_W       = 32;
	localparam logic        EDGE_RST     = 1'b1;
	localparam logic        MODE_RST     = 1'b0;
	localparam logic [7:0]  DOUT_RST     = 8'h00;
	localparam logic [7:0]  DDIR_RST     = 8'h00;
	localparam logic [31:0] COUNT_RST    = 32'h00000000;

	// ==============================================================
	// Input filter depth: pin passes this many stage flops, then a level flop
	localparam int SYNC_STAGES = 3;

endpackage

// *** etdr_sync.sv ***
// ==============================================================
// Pin synchroniser with agreement filter
// Three stage flops and a level flop per bit; the filtered level only moves when the
// second and third flop agree, so a one-cycle glitch is ignored.
module etdr_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst,
	// Raw pins and filtered levels
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] level_q
);

	genvar i;

	// ==============================================================
	// One filter per bit
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic s1_q;            // Metastable stage, read by s2 only
			logic s2_q;            // Second stage
			logic s3_q;            // Third stage
			logic lvl_d;           // Next filtered level

			// Accept a change only when stages two and three agree
			always_comb begin
				lvl_d = level_q[i];
				if (s2_q == s3_q) begin
					lvl_d = s3_q;
				end
			end

			// Register chain
			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					s1_q       <= 1'b0;
					s2_q       <= 1'b0;
					s3_q       <= 1'b0;
					level_q[i] <= 1'b0;
				end else begin
					s1_q       <= pin_in[i];
					s2_q       <= s1_q;
					s3_q       <= s2_q;
					level_q[i] <= lvl_d;
				end
			end
		end
	endgenerate

endmodule

// *** etdr_totalizer.sv ***
// Notes on behaviour
// - Count on rising or falling edge, selectable
// - Plain read returns count, keeps counting
// - Read-then-clear mode zeroes count after read
// - Clear command zeroes count at once
// - Output channel bit read returns pin level
// - Input channel releases drivers, reads external level
// - Unconnected gate means counting always enabled
module etdr_totalizer (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// Totalizer pins
	input  wire logic        count_in,
	input  wire logic        gate_in,
	input  wire logic        gate_present,
	// Digital I/O pins
	input  wire logic [7:0]  dio_in,
	output logic      [7:0]  dio_out,
	output logic      [7:0]  dio_oe
);

	// ==============================================================
	// Declarations
	logic [2:0]  pin_lvl;                // Filtered count, gate, presence
	logic [7:0]  dio_lvl;                // Filtered digital pin levels
	logic        cnt_prev_q;             // Count level one cycle ago
	logic        cnt_prev_d;
	logic        edge_hit;               // Qualified count edge this cycle
	logic        gate_open;              // Gate enables counting
	logic        count_edge_select_q;    // 1 = rising edge
	logic        count_edge_select_d;
	logic        count_read_mode_q;      // 1 = read_then_clear_mode
	logic        count_read_mode_d;
	logic        count_clear_now;        // Clear strobe from a write
	logic        count_rd;               // Read of the count register
	logic [31:0] count_q;                // Running total
	logic [31:0] count_d;
	logic [7:0]  dout_q;                 // Driven output pattern
	logic [7:0]  dout_d;
	logic [7:0]  ddir_q;                 // 1 = bit is an output
	logic [7:0]  ddir_d;
	logic [31:0] rdata_q;                // Read data, one cycle after strobe
	logic [31:0] rdata_d;

	// ==============================================================
	// Pin filters
	etdr_sync #(.WIDTH(3)) u_tot_sync (
		.ref_clk (ref_clk),
		.rst     (rst),
		.pin_in  ({gate_present, gate_in, count_in}),
		.level_q (pin_lvl)
	);

	etdr_sync #(.WIDTH(etdr_pkg::DIO_W)) u_dio_sync (
		.ref_clk (ref_clk),
		.rst     (rst),
		.pin_in  (dio_in),
		.level_q (dio_lvl)
	);

	// ==============================================================
	// Edge detection
	// Missing gate wire is treated as a pulled-up enable
	assign gate_open = !pin_lvl[2] || pin_lvl[1];

	// Pick the edge by the configured polarity
	always_comb begin
		cnt_prev_d = pin_lvl[0];
		if (count_edge_select_q) begin
			edge_hit = gate_open && pin_lvl[0] && !cnt_prev_q;
		end else begin
			edge_hit = gate_open && !pin_lvl[0] && cnt_prev_q;
		end
	end

	// ==============================================================
	// Register decode
	assign count_clear_now = reg_wr && (reg_addr == etdr_pkg::CTRL_ADDR)
	                         && reg_wdata[etdr_pkg::CTRL_CLEAR_BIT];
	assign count_rd        = reg_rd && (reg_addr == etdr_pkg::COUNT_ADDR);

	// Configuration writes
	always_comb begin
		count_edge_select_d = count_edge_select_q;
		count_read_mode_d   = count_read_mode_q;
		dout_d              = dout_q;
		ddir_d              = ddir_q;
		if (reg_wr) begin
			case (reg_addr)
				etdr_pkg::CTRL_ADDR: begin
					count_edge_select_d = reg_wdata[etdr_pkg::CTRL_EDGE_BIT];
					count_read_mode_d   = reg_wdata[etdr_pkg::CTRL_MODE_BIT];
				end
				etdr_pkg::DOUT_ADDR: begin
					dout_d = reg_wdata[7:0];
				end
				etdr_pkg::DDIR_ADDR: begin
					ddir_d = reg_wdata[7:0];
				end
				default: begin
					// Unmapped or read-only: ignored
				end
			endcase
		end
	end

	// ==============================================================
	// Counter
	// A clear or clearing read restarts from the edge of this cycle,
	// so an edge that coincides with the clear is never dropped.
	always_comb begin
		if (count_clear_now) begin
			count_d = {31'h00000000, edge_hit};
		end else if (count_rd && count_read_mode_q) begin
			count_d = {31'h00000000, edge_hit};
		end else begin
			count_d = count_q + {31'h00000000, edge_hit};
		end
	end

	// ==============================================================
	// Read mux
	// Bit reads always see the filtered pin, so a driven output
	// reads back what is really on the wire, not the stored copy.
	always_comb begin
		rdata_d = 32'h00000000;
		if (reg_rd) begin
			case (reg_addr)
				etdr_pkg::CTRL_ADDR: begin
					rdata_d = {30'h00000000, count_read_mode_q, count_edge_select_q};
				end
				etdr_pkg::COUNT_ADDR: begin
					rdata_d = count_q;
				end
				etdr_pkg::DOUT_ADDR: begin
					rdata_d = {24'h000000, dout_q};
				end
				etdr_pkg::DDIR_ADDR: begin
					rdata_d = {24'h000000, ddir_q};
				end
				etdr_pkg::DBITS_ADDR: begin
					rdata_d = {24'h000000, dio_lvl};
				end
				default: begin
					rdata_d = 32'h00000000;
				end
			endcase
		end
	end

	// ==============================================================
	// State registers
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt_prev_q          <= 1'b0;
			count_edge_select_q <= etdr_pkg::EDGE_RST;
			count_read_mode_q   <= etdr_pkg::MODE_RST;
			count_q             <= etdr_pkg::COUNT_RST;
			dout_q              <= etdr_pkg::DOUT_RST;
			ddir_q              <= etdr_pkg::DDIR_RST;
			rdata_q             <= 32'h00000000;
		end else begin
			cnt_prev_q          <= cnt_prev_d;
			count_edge_select_q <= count_edge_select_d;
			count_read_mode_q   <= count_read_mode_d;
			count_q             <= count_d;
			dout_q              <= dout_d;
			ddir_q              <= ddir_d;
			rdata_q             <= rdata_d;
		end
	end

	// ==============================================================
	// Outputs
	assign reg_rdata = rdata_q;
	assign dio_out   = dout_q;
	// Input bits release their drivers
	assign dio_oe    = ddir_q;

	// ==============================================================
	// Assertions
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	a_edge_counted: assert property (edge_hit && !count_clear_now && !count_rd
		|=> count_q == $past(count_q) + 32'h00000001)
		else $error("qualified edge not counted");
	a_rise_only: assert property (count_edge_select_q && gate_open
		&& pin_lvl[0] && !cnt_prev_q |-> edge_hit)
		else $error("rising edge missed");
	a_fall_only: assert property (!count_edge_select_q && pin_lvl[0]
		|-> !edge_hit)
		else $error("falling mode counted on high level");
	a_plain_read: assert property (count_rd && !count_read_mode_q
		&& !count_clear_now |=> reg_rdata == $past(count_q)
		&& count_q == $past(count_q) + {31'h00000000, $past(edge_hit)})
		else $error("plain read disturbed count");
	a_read_clear: assert property (count_rd && count_read_mode_q
		|=> reg_rdata == $past(count_q)
		&& count_q == {31'h00000000, $past(edge_hit)})
		else $error("read then clear failed");
	a_clear_now: assert property (count_clear_now
		|=> count_q == {31'h00000000, $past(edge_hit)})
		else $error("clear command failed");
	a_bit_readback: assert property (reg_rd && reg_addr == etdr_pkg::DBITS_ADDR
		|=> reg_rdata[7:0] == $past(dio_lvl))
		else $error("bit read not pin level");
	a_input_release: assert property (reg_wr && reg_addr == etdr_pkg::DDIR_ADDR
		|=> dio_oe == $past(reg_wdata[7:0]))
		else $error("direction not applied to drivers");
	a_gate_float: assert property (!pin_lvl[2] && count_edge_select_q
		&& pin_lvl[0] && !cnt_prev_q |-> edge_hit)
		else $error("floating gate blocked count");
	a_gate_shut: assert property (pin_lvl[2] && !pin_lvl[1]
		|-> !edge_hit)
		else $error("closed gate counted");

	c_rtc_read:  cover property (count_rd && count_read_mode_q && edge_hit);
	c_clear_hit: cover property (count_clear_now && edge_hit);
	c_fall_cnt:  cover property (!count_edge_select_q && edge_hit);
	c_bit_out:   cover property (reg_rd && reg_addr == etdr_pkg::DBITS_ADDR && dio_oe != 8'h00);

endmodule

// *** etdr_far_side.sv ***
// ==============================================================
// Far side: pulse source and the resolved digital channel wire
module etdr_far_side (
	// Clock
	input  wire logic       ref_clk,
	// Pulse train request
	input  wire logic [7:0] pulse_num,
	input  wire logic       pulse_go,
	output logic            pulse_busy,
	// Totalizer pin
	output logic            count_in,
	// Digital channel wire
	input  wire logic [7:0] dio_out,
	input  wire logic [7:0] dio_oe,
	input  wire logic [7:0] dio_ext,
	output logic      [7:0] dio_in
);
	timeunit 1ns;
	timeprecision 1ns;

	// Driven bits show the driver, released bits the outside level
	assign dio_in = (dio_oe & dio_out) | (~dio_oe & dio_ext);

	initial begin
		count_in = 1'b0;
		pulse_busy = 1'b0;
	end

	// Three cycles per level, so each level outlasts the input filter
	always @(posedge ref_clk) begin
		if (pulse_go && !pulse_busy) begin
			pulse_busy <= 1'b1;
			for (int i = 0; i < pulse_num; i++) begin
				count_in <= 1'b1;
				repeat (3) @(posedge ref_clk);
				count_in <= 1'b0;
				repeat (3) @(posedge ref_clk);
			end
			pulse_busy <= 1'b0;
		end
	end
endmodule

// *** tb_edge_totalizer_with_dio_readback.sv ***
module tb_edge_totalizer_with_dio_readback;
	timeunit 1ns;
	timeprecision 1ns;

	// ==============================================================
	// Bench signals
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h00000000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic        count_in;
	logic        gate_in = 1'b0;
	logic        gate_present = 1'b0;
	logic [7:0]  dio_in;
	logic [7:0]  dio_out;
	logic [7:0]  dio_oe;
	logic [7:0]  dio_ext = 8'hA5;
	logic [7:0]  pulse_num = 8'h00;
	logic        pulse_go = 1'b0;
	logic        pulse_busy;
	logic [31:0] d;
	logic [31:0] sum;
	int          err_total = 0;
	int          checks = 0;

	always #50 ref_clk = ~ref_clk;

	etdr_totalizer etdr_totalizer_inst (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.count_in(count_in), .gate_in(gate_in), .gate_present(gate_present),
		.dio_in(dio_in), .dio_out(dio_out), .dio_oe(dio_oe));

	etdr_far_side etdr_far_side_inst (.ref_clk(ref_clk), .pulse_num(pulse_num),
		.pulse_go(pulse_go), .pulse_busy(pulse_busy), .count_in(count_in),
		.dio_out(dio_out), .dio_oe(dio_oe), .dio_ext(dio_ext), .dio_in(dio_in));

	// ==============================================================
	// Verdict and comparison
	task automatic summarize();
		if (err_total == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	// ==============================================================
	// Register port cycles: data stands only in the cycle after the strobe
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		v = reg_rdata;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string name);
		logic [31:0] v;
		rd(a, v);
		chk(name, exp, v);
	endtask

	// ==============================================================
	// Pulse trains; the wait is bounded and a hang ends the run
	task automatic start_train(input logic [7:0] n);
		@(posedge ref_clk);
		pulse_num <= n;
		pulse_go <= 1'b1;
		@(posedge ref_clk);
		pulse_go <= 1'b0;
	endtask

	task automatic wait_train();
		int k;
		// Busy rises only at the go edge, so look first at the next low phase
		@(negedge ref_clk);
		for (k = 0; k < 400 && pulse_busy !== 1'b0; k++)
			@(negedge ref_clk);
		if (k == 400) begin
			err_total++;
			summarize();
		end
		// Let the filter and the counter settle
		repeat (8) @(posedge ref_clk);
	endtask

	// ==============================================================
	// Main sequence
	initial begin
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		rdc(etdr_pkg::CTRL_ADDR, 32'h00000001, "ctrl reset");
		chk("oe reset", 32'h00000000, {24'h000000, dio_oe});
		start_train(8'h05);
		wait_train();
		rdc(etdr_pkg::COUNT_ADDR, 32'h00000005, "rising count");
		rdc(etdr_pkg::COUNT_ADDR, 32'h00000005, "plain reread");
		wr(etdr_pkg::CTRL_ADDR, 32'h00000000);
		start_train(8'h03);
		wait_train();
		rdc(etdr_pkg::COUNT_ADDR, 32'h00000008, "falling count");
		wr(etdr_pkg::CTRL_ADDR, 32'h00000004);
		rdc(etdr_pkg::COUNT_ADDR, 32'h00000000, "clear now");
		wr(etdr_pkg::CTRL_ADDR, 32'h00000003);
		start_train(8'h02);
		wait_train();
		rdc(etdr_pkg::COUNT_ADDR, 32'h00000002, "clearing read");
		rdc(etdr_pkg::COUNT_ADDR, 32'h00000000, "after clear");
		// Closed gate blocks the count
		@(posedge ref_clk);
		gate_present <= 1'b1;
		start_train(8'h02);
		wait_train();
		rdc(etdr_pkg::COUNT_ADDR, 32'h00000000, "gate closed");
		// Wired gate held high lets edges through, then absent gate counts
		@(posedge ref_clk);
		gate_in <= 1'b1;
		start_train(8'h02);
		wait_train();
		rdc(etdr_pkg::COUNT_ADDR, 32'h00000002, "gate open");
		@(posedge ref_clk);
		gate_present <= 1'b0;
		gate_in <= 1'b0;
		start_train(8'h02);
		wait_train();
		rdc(etdr_pkg::COUNT_ADDR, 32'h00000002, "gate absent");
		// Back-to-back clearing reads during a train lose no edge
		sum = 32'h00000000;
		start_train(8'h04);
		repeat (16) begin
			rd(etdr_pkg::COUNT_ADDR, d);
			sum = sum + d;
		end
		wait_train();
		rd(etdr_pkg::COUNT_ADDR, d);
		chk("read sum", 32'h00000004, sum + d);
		// Digital channel readback
		wr(etdr_pkg::DOUT_ADDR, 32'h00000040);
		wr(etdr_pkg::DDIR_ADDR, 32'h000000FF);
		repeat (6) @(posedge ref_clk);
		rdc(etdr_pkg::DBITS_ADDR, 32'h00000040, "output bits");
		chk("dout pins", 32'h00000040, {24'h000000, dio_out});
		chk("oe driven", 32'h000000FF, {24'h000000, dio_oe});
		rdc(etdr_pkg::DOUT_ADDR, 32'h00000040, "dout reg");
		rdc(etdr_pkg::DDIR_ADDR, 32'h000000FF, "ddir reg");
		wr(etdr_pkg::DDIR_ADDR, 32'h0000000F);
		repeat (6) @(posedge ref_clk);
		rdc(etdr_pkg::DBITS_ADDR, 32'h000000A0, "mixed bits");
		wr(etdr_pkg::DDIR_ADDR, 32'h00000000);
		repeat (6) @(posedge ref_clk);
		rdc(etdr_pkg::DBITS_ADDR, 32'h000000A5, "input bits");
		chk("oe released", 32'h00000000, {24'h000000, dio_oe});
		rdc(8'h20, 32'h00000000, "unmapped");
		summarize();
	end
endmodule
